// ---- verilog/pss_sequencer.sv ----
// program sequencer: phases, fetch pipeline, counter, vectors, table reads
// assumes a program memory answering within the cycle and a decoder that
// reports the executing instruction's operation by the last phase
`timescale 1ns/1ns
module pss_sequencer
  import pss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  output logic [PC_W-1:0]        prog_addr,
  input  wire logic [WORD_W-1:0] prog_data,
  output logic [WORD_W-1:0]      instr_word,
  output logic                   instr_valid,
  input  wire pss_op_type        exec_op,
  input  wire logic [PC_W-1:0]   exec_addr,
  input  wire logic [7:0]        mem_addr,
  input  wire logic              mem_wr,
  input  wire logic [7:0]        mem_wdata,
  output logic [7:0]             mem_rdata,
  input  wire logic [IRQ_N-1:0]  irq_req,
  output logic [IRQ_N-1:0]       irq_ack,
  output logic [7:0]             table_low_byte,
  output logic                   table_low_valid,
  output logic [3:0]             phase,
  output logic                   cycle_end
);
  // ----------------------------------------------------------------
  // state and internal signals
  // ----------------------------------------------------------------
  pss_state_type   state;
  pss_state_type   next_state;
  pss_op_type      op;
  logic [PC_W-1:0] program_counter;
  logic [PC_W-1:0] next_pc;
  logic [7:0]      table_pointer;
  logic [7:0]      table_high_byte;
  logic [PC_W-1:0] table_addr;
  logic [PC_W-1:0] vector;
  logic [IRQ_N-1:0] grant;
  logic            low_write;
  logic            take_irq;
  logic            flush;
  logic            is_table;

  pss_stack_if stk ();

  pss_phase_gen phase_gen (
    .clk       (clk),
    .reset     (reset),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  pss_return_stack return_stack (
    .clk   (clk),
    .reset (reset),
    .port  (stk.stack)
  );

  // ----------------------------------------------------------------
  // decode of the executing slot
  // ----------------------------------------------------------------
  // a dummy slot behaves as a plain sequential step
  assign op        = instr_valid ? exec_op : PSS_OP_NEXT;
  assign low_write = mem_wr && (mem_addr == PC_LOW_OFFSET);
  assign is_table  = (op == PSS_OP_TABC) || (op == PSS_OP_TABL);

  // lowest vector first among pending requests
  always_comb begin
    grant  = '0;
    vector = RESET_VECTOR;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        grant  = '0;
        grant[i] = 1'b1;
        vector = VECTOR_STEP * PC_W'(i + 1);
      end
    end
  end

  // acknowledge only between plain steps and never onto a full stack
  assign take_irq = (state == PSS_RUN) && (op == PSS_OP_NEXT) && !low_write
                    && (irq_req != '0) && !stk.full;

  // table address: current page or last page
  assign table_addr = (op == PSS_OP_TABL) ? {LAST_PAGE, table_pointer}
                                          : {program_counter[12:8], table_pointer};

  // ----------------------------------------------------------------
  // next counter value at the end of an instruction cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_pc    = program_counter + 1'b1;
    next_state = PSS_RUN;
    flush      = 1'b0;
    if (state == PSS_TABLE) begin
      next_pc = program_counter; // table access cycle fetches nothing
    end else if (low_write) begin
      next_pc = {program_counter[12:8], mem_wdata};
      flush   = 1'b1;
    end else if (take_irq) begin
      next_pc = vector;
      flush   = 1'b1;
    end else begin
      unique case (op)
        PSS_OP_NEXT: begin
          flush = 1'b0;
        end
        PSS_OP_SKIP: begin
          flush = 1'b1;
        end
        PSS_OP_JUMP, PSS_OP_CALL: begin
          next_pc = exec_addr;
          flush   = 1'b1;
        end
        PSS_OP_RETURN, PSS_OP_RETURN_IRQ: begin
          next_pc = stk.pop_addr;
          flush   = 1'b1;
        end
        PSS_OP_TABC, PSS_OP_TABL: begin
          next_state = PSS_TABLE;
        end
      endcase
    end
  end

  // stack requests, one clock wide at the cycle end
  assign stk.push      = cycle_end && (state == PSS_RUN) && !low_write
                         && (take_irq || op == PSS_OP_CALL);
  assign stk.pop       = cycle_end && (state == PSS_RUN) && !low_write && !take_irq
                         && (op == PSS_OP_RETURN || op == PSS_OP_RETURN_IRQ);
  assign stk.push_addr = program_counter; // address of the prefetched word

  // ----------------------------------------------------------------
  // counter, state and memory address
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      program_counter <= RESET_VECTOR;
      state           <= PSS_RUN;
      prog_addr       <= RESET_VECTOR;
    end else if (cycle_end) begin
      program_counter <= next_pc;
      state           <= next_state;
      prog_addr       <= (next_state == PSS_TABLE) ? table_addr : next_pc;
    end
  end

  // ----------------------------------------------------------------
  // fetch stage
  // ----------------------------------------------------------------
  // the word fetched this cycle executes next; a transfer turns it into a dummy
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_word  <= '0;
      instr_valid <= 1'b0;
    end else if (cycle_end && state == PSS_RUN) begin
      instr_word  <= prog_data;
      instr_valid <= !flush;
    end
  end

  // ----------------------------------------------------------------
  // table data and interrupt acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      table_high_byte <= BYTE_RESET;
      table_low_byte  <= BYTE_RESET;
      table_low_valid <= 1'b0;
    end else begin
      table_low_valid <= cycle_end && (state == PSS_TABLE);
      if (cycle_end && state == PSS_TABLE) begin
        table_low_byte  <= prog_data[7:0];
        table_high_byte <= prog_data[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ack <= '0;
    end else begin
      irq_ack <= (cycle_end && take_irq) ? grant : '0;
    end
  end

  // ----------------------------------------------------------------
  // data memory mapped registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      table_pointer <= BYTE_RESET;
    end else if (cycle_end && mem_wr && mem_addr == TABLE_PTR_OFFSET) begin
      table_pointer <= mem_wdata;
    end
  end

  // read mux; high byte ignores writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_rdata <= BYTE_RESET;
    end else begin
      unique case (mem_addr)
        PC_LOW_OFFSET:     mem_rdata <= program_counter[7:0];
        TABLE_PTR_OFFSET:  mem_rdata <= table_pointer;
        TABLE_HIGH_OFFSET: mem_rdata <= table_high_byte;
        default:     mem_rdata <= BYTE_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  reset_start_a: assert property ($past(reset) && !reset |->
    program_counter == RESET_VECTOR && stk.empty && !instr_valid)
    else $error("reset did not start at zero with empty stack");

  seq_step_a: assert property (cycle_end && state == PSS_RUN && op == PSS_OP_NEXT
    && !low_write && !take_irq |=> program_counter == $past(program_counter) + 1'b1)
    else $error("sequential step did not add one");

  low_byte_jump_a: assert property (cycle_end && state == PSS_RUN && low_write |=>
    program_counter == {$past(program_counter[12:8]), $past(mem_wdata)} && !instr_valid)
    else $error("low byte write jumped wrongly");

  jump_load_a: assert property (cycle_end && state == PSS_RUN && !low_write && !take_irq
    && (op == PSS_OP_JUMP || op == PSS_OP_CALL) |=> program_counter == $past(exec_addr))
    else $error("jump did not load the address field");

  // the discarded slot stays a dummy for the whole next instruction cycle
  transfer_flush_a: assert property (cycle_end && flush |=>
    !instr_valid [*4])
    else $error("transfer did not insert a dummy cycle");

  irq_vector_a: assert property (cycle_end && take_irq |=>
    irq_ack != '0 && program_counter == VECTOR_STEP * PC_W'($clog2(int'(irq_ack)) + 1))
    else $error("interrupt vector wrong");

  full_hold_a: assert property (stk.full && !stk.pop |=> irq_ack == '0)
    else $error("interrupt acknowledged onto a full stack");

  table_two_a: assert property (cycle_end && state == PSS_RUN && is_table && !low_write
    && !take_irq |=> state == PSS_TABLE [*4] ##1 state == PSS_RUN ##0 table_low_valid)
    else $error("table read did not take two cycles");
endmodule

// ---- shared/pss_pkg.sv ----
// constants and types of the program sequencer and return stack
// assumes one system clock and a synchronous active high reset
// Function
// - four system clocks form one instruction cycle
// - fetch next word while current one executes
// - counter changing instructions take two cycles
// - program counter is thirteen bits wide
// - counter advances by one after each fetch
// - true skip discards prefetched word, dummy cycle
// - low byte write replaces counter bits seven..zero
// - jump, call load address field; return pops
// - reset clears counter to address zero
// - external interrupts vector to 004 and 008
// - timer overflows vector to 00c and 010
// - time base 014, real time clock 018
// - program memory addressed by counter or pointer
// - current page table read uses counter page
// - last page table read uses all ones page
// - table reads take two cycles; high byte read-only
// - sixteen entry stack hidden from software
// - call or acknowledge pushes, return pops
// - reset leaves the return stack empty
// - full stack withholds interrupt acknowledge until pop
// - call on full stack drops oldest entry
package pss_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W        = 13;
  localparam int WORD_W      = 16;
  localparam int STACK_DEPTH = 16;
  localparam int SIDX_W      = 4;
  localparam int IRQ_N       = 6;
  localparam int PHASES      = 4;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PC_LOW_OFFSET     = 8'h06;
  localparam logic [7:0] TABLE_PTR_OFFSET  = 8'h07;
  localparam logic [7:0] TABLE_HIGH_OFFSET = 8'h08;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [4:0] LAST_PAGE  = 5'h1f;
  localparam logic [PC_W-1:0] VECTOR_STEP = 13'h0004;
  // ----------------------------------------------------------------
  // operations reported by the decoder and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSS_OP_NEXT  = 3'b000,
    PSS_OP_SKIP  = 3'b001,
    PSS_OP_JUMP  = 3'b010,
    PSS_OP_CALL  = 3'b011,
    PSS_OP_RETURN     = 3'b100,
    PSS_OP_RETURN_IRQ = 3'b101,
    PSS_OP_TABC  = 3'b110,
    PSS_OP_TABL  = 3'b111
  } pss_op_type;
  typedef enum logic {
    PSS_RUN   = 1'b0,
    PSS_TABLE = 1'b1
  } pss_state_type;
endpackage

// ---- shared/pss_stack_if.sv ----
// push and pop signals between sequencer and return stack
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface pss_stack_if;
  import pss_pkg::*;
  logic              push;
  logic              pop;
  logic [PC_W-1:0]   push_addr;
  logic [PC_W-1:0]   pop_addr;
  logic              full;
  logic              empty;
  modport seq   (output push, pop, push_addr, input pop_addr, full, empty);
  modport stack (input push, pop, push_addr, output pop_addr, full, empty);
endinterface

// ---- verilog/pss_phase_gen.sv ----
// four phase generator of the instruction cycle
// assumes the system clock and synchronous reset of the core
`timescale 1ns/1ns
module pss_phase_gen
  import pss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  output logic [3:0]      phase,
  output logic            cycle_end
);
  logic [1:0] count;

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'h1;
    end
  end

  // one-hot non-overlapping phases
  assign phase     = 4'h1 << count;
  assign cycle_end = (count == LAST_PHASE);

  phase_ring_a: assert property (@(posedge clk) disable iff (reset)
    cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle is not four clocks");
endmodule

// ---- verilog/pss_return_stack.sv ----
// sixteen level return stack, circular so a full push drops the oldest
// assumes push and pop never come in the same clock
`timescale 1ns/1ns
module pss_return_stack
  import pss_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  pss_stack_if.stack port
);
  logic [PC_W-1:0]   entry [STACK_DEPTH];
  logic [SIDX_W-1:0] stack_index;
  logic [SIDX_W:0]   depth;

  // ----------------------------------------------------------------
  // storage, hidden from software
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (port.push) begin
      entry[stack_index] <= port.push_addr;
    end
  end

  // pointer and fill level; reset means empty
  always_ff @(posedge clk) begin
    if (reset) begin
      stack_index <= '0;
      depth       <= '0;
    end else if (port.push) begin
      stack_index <= stack_index + 1'b1;
      if (!port.full) begin
        depth <= depth + 1'b1;
      end // full push overwrites oldest
    end else if (port.pop && !port.empty) begin
      stack_index <= stack_index - 1'b1;
      depth       <= depth - 1'b1;
    end
  end

  assign port.pop_addr = entry[stack_index - 1'b1];
  assign port.full     = (depth == STACK_DEPTH[SIDX_W:0]);
  assign port.empty    = (depth == '0);

  overflow_keep_a: assert property (@(posedge clk) disable iff (reset)
    port.push && port.full |=> port.full && $past(port.push_addr) == port.pop_addr)
    else $error("full push lost the newest entry");
endmodule

// ---- sim/pss_prog_mem.sv ----
// program memory model: 8192 words of 16 bits, content fixed by address
// assumes the address stands for a whole instruction cycle
`timescale 1ns/1ns
module pss_prog_mem
  import pss_pkg::*;
#(
  parameter int LATENCY = 0
)
(
  input  wire logic              clk,
  input  wire logic [PC_W-1:0]   addr,
  output logic [WORD_W-1:0]      data
);
  logic [PC_W-1:0] last_addr;
  int              age;

  // ------------------------------------------------------------
  // word content and settling delay
  // ------------------------------------------------------------
  function automatic logic [WORD_W-1:0] word_at(input logic [PC_W-1:0] a);
    return {3'h5, a} ^ 16'h00A5;
  endfunction

  // count clocks since the address last moved
  always_ff @(posedge clk) begin
    if (addr !== last_addr) begin
      last_addr <= addr;
      age       <= 0;
    end else if (age < LATENCY) begin
      age <= age + 1;
    end
  end

  // inverse pattern until settled, so stale data never looks right
  assign data = (addr === last_addr && age >= LATENCY) ? word_at(addr)
                                                      : ~word_at(addr);
endmodule

// ---- sim/program_sequencer_stack_tb_top.sv ----
// testbench of the program sequencer with a slow program memory
// assumes a 250 MHz clock and inputs driven on the falling edge
`timescale 1ns/1ns
module program_sequencer_stack_tb_top;
  import pss_pkg::*;
  logic              clk;
  logic              reset;
  logic [PC_W-1:0]   prog_addr;
  logic [WORD_W-1:0] prog_data;
  logic [WORD_W-1:0] instr_word;
  logic              instr_valid;
  pss_op_type        exec_op;
  logic [PC_W-1:0]   exec_addr;
  logic [7:0]        mem_addr;
  logic              mem_wr;
  logic [7:0]        mem_wdata;
  logic [7:0]        mem_rdata;
  logic [IRQ_N-1:0]  irq_req;
  logic [IRQ_N-1:0]  irq_ack;
  logic [7:0]        table_low_byte;
  logic              table_low_valid;
  logic [3:0]        phase;
  logic              cycle_end;
  int                mismatches;
  int                checks_done;
  int                k;
  int                n;
  logic [7:0]        rv;

  pss_sequencer u_dut (.clk(clk), .reset(reset), .prog_addr(prog_addr),
    .prog_data(prog_data), .instr_word(instr_word), .instr_valid(instr_valid),
    .exec_op(exec_op), .exec_addr(exec_addr), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_ack(irq_ack),
    .table_low_byte(table_low_byte), .table_low_valid(table_low_valid),
    .phase(phase), .cycle_end(cycle_end));
  pss_prog_mem #(.LATENCY(2)) u_mem (.clk(clk), .addr(prog_addr), .data(prog_data));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [WORD_W-1:0] wd_at(input logic [PC_W-1:0] a);
    return {3'h5, a} ^ 16'h00A5;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // drive one instruction cycle's inputs up to its closing edge
  task automatic cyc(input pss_op_type o, input logic [PC_W-1:0] t, input logic wr,
                     input logic [7:0] wa, input logic [7:0] wd, input logic [IRQ_N-1:0] rq);
    int m;
    m = 0;
    while (cycle_end !== 1'b1 && m < 8) begin
      @(negedge clk);
      m++;
    end
    if (m == 8) chk("cycle_end wait", 16'h0001, 16'h0000);
    exec_op   = o;
    exec_addr = t;
    mem_wr    = wr;
    mem_addr  = wa;
    mem_wdata = wd;
    irq_req   = rq;
    @(negedge clk);
    exec_op = PSS_OP_NEXT;
    mem_wr  = 1'b0;
    irq_req = 6'h00;
  endtask

  task automatic op(input pss_op_type o, input logic [PC_W-1:0] t);
    cyc(o, t, 1'b0, 8'h00, 8'h00, 6'h00);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    mem_addr = a;
    @(negedge clk);
    v = mem_rdata;
  endtask

  task automatic wait_table();
    n = 0;
    while (table_low_valid !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #40000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    mismatches = 0;
    checks_done = 0;
    reset = 1'b1;
    exec_op = PSS_OP_NEXT;
    exec_addr = 13'h0000;
    mem_addr = 8'h00;
    mem_wr = 1'b0;
    mem_wdata = 8'h00;
    irq_req = 6'h00;
    repeat (16) @(negedge clk);
    chk("prog_addr reset", 16'h0000, prog_addr);
    chk("phase reset", 16'h0001, phase);
    reset = 1'b0;
    for (k = 6; k < 9; k++) begin
      rd(8'(k), rv);
      chk("byte reset", 16'h0000, rv);
    end
    // first fetch from zero, then steady flow
    op(PSS_OP_NEXT, 13'h0000);
    chk("first word", wd_at(13'h0000), instr_word);
    chk("prog_addr +1", 16'h0001, prog_addr);
    chk("phase after end", 16'h0001, phase);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (cycle_end === 1'b1) n++;
    end
    chk("cycle_end count", 16'h0002, 16'(n));
    op(PSS_OP_NEXT, 13'h0000);
    chk("valid flow", 16'h0001, instr_valid);
    chk("prog_addr flow", 16'h0004, prog_addr);
    // jump, dummy, taken skip
    op(PSS_OP_JUMP, 13'h0123);
    chk("jump addr", 16'h0123, prog_addr);
    chk("jump dummy", 16'h0000, instr_valid);
    op(PSS_OP_NEXT, 13'h0000);
    chk("jump word", wd_at(13'h0123), instr_word);
    op(PSS_OP_SKIP, 13'h0000);
    chk("skip addr", 16'h0125, prog_addr);
    chk("skip dummy", 16'h0000, instr_valid);
    op(PSS_OP_NEXT, 13'h0000);
    chk("after skip", wd_at(13'h0125), instr_word);
    // short jump through the low byte
    cyc(PSS_OP_NEXT, 13'h0000, 1'b1, PC_LOW_OFFSET, 8'h40, 6'h00);
    chk("low byte jump", 16'h0140, prog_addr);
    op(PSS_OP_NEXT, 13'h0000);
    // table pointer and both table reads
    cyc(PSS_OP_NEXT, 13'h0000, 1'b1, TABLE_PTR_OFFSET, 8'h5A, 6'h00);
    rd(TABLE_PTR_OFFSET, rv);
    chk("table_pointer", 16'h005A, rv);
    op(PSS_OP_TABC, 13'h0000);
    chk("current page addr", 16'h015A, prog_addr);
    wait_table();
    chk("table low", 16'(wd_at(13'h015A) & 16'h00FF), table_low_byte);
    rd(TABLE_HIGH_OFFSET, rv);
    chk("table_high_byte", 16'(wd_at(13'h015A) >> 8), rv);
    cyc(PSS_OP_NEXT, 13'h0000, 1'b1, TABLE_HIGH_OFFSET, 8'hFF, 6'h00);
    rd(TABLE_HIGH_OFFSET, rv);
    chk("high byte kept", 16'(wd_at(13'h015A) >> 8), rv);
    op(PSS_OP_TABL, 13'h0000);
    chk("last page addr", 16'h1F5A, prog_addr);
    wait_table();
    chk("last page low", 16'(wd_at(13'h1F5A) & 16'h00FF), table_low_byte);
    // call and return
    op(PSS_OP_JUMP, 13'h0200);
    op(PSS_OP_NEXT, 13'h0000);
    op(PSS_OP_CALL, 13'h0400);
    chk("call addr", 16'h0400, prog_addr);
    op(PSS_OP_NEXT, 13'h0000);
    op(PSS_OP_RETURN, 13'h0000);
    chk("return addr", 16'h0201, prog_addr);
    op(PSS_OP_NEXT, 13'h0000);
    // every vector, lowest pending first
    for (k = 0; k < IRQ_N; k++) begin
      cyc(PSS_OP_NEXT, 13'h0000, 1'b0, 8'h00, 8'h00, 6'(6'h3F << k));
      chk("vector", 16'(VECTOR_STEP * (k + 1)), prog_addr);
      chk("irq_ack", 16'(6'h01 << k), irq_ack);
      op(PSS_OP_NEXT, 13'h0000);
      op(PSS_OP_RETURN_IRQ, 13'h0000);
      chk("return_from_interrupt addr", 16'(13'h0202 + k), prog_addr);
      op(PSS_OP_NEXT, 13'h0000);
    end
    // fill the stack, withhold an interrupt, overflow once
    op(PSS_OP_JUMP, 13'h0200);
    op(PSS_OP_NEXT, 13'h0000);
    for (k = 0; k < 16; k++) begin
      op(PSS_OP_CALL, 13'(13'h0800 + 16 * k));
      op(PSS_OP_NEXT, 13'h0000);
    end
    cyc(PSS_OP_NEXT, 13'h0000, 1'b0, 8'h00, 8'h00, 6'h3F);
    chk("full no vector", 16'h08F2, prog_addr);
    chk("full no ack", 16'h0000, irq_ack);
    op(PSS_OP_CALL, 13'h0900);
    op(PSS_OP_NEXT, 13'h0000);
    op(PSS_OP_RETURN, 13'h0000);
    chk("newest entry", 16'h08F2, prog_addr);
    op(PSS_OP_NEXT, 13'h0000);
    cyc(PSS_OP_NEXT, 13'h0000, 1'b0, 8'h00, 8'h00, 6'h20);
    chk("served after pop", 16'h0018, prog_addr);
    op(PSS_OP_NEXT, 13'h0000);
    op(PSS_OP_RETURN_IRQ, 13'h0000);
    chk("return_from_interrupt from full", 16'h08F3, prog_addr);
    op(PSS_OP_NEXT, 13'h0000);
    for (k = 14; k >= 0; k--) begin
      op(PSS_OP_RETURN, 13'h0000);
      chk("pop order", 16'(13'h0801 + 16 * k), prog_addr);
      op(PSS_OP_NEXT, 13'h0000);
    end
    tally_and_finish();
  end
endmodule
